// ### rtl/ssw_top.sv
// supply supervisor timing core: reset timer, watchdog, APB register slave
// assumes analog comparators feed supply_valid and lockout_ok asynchronously
`timescale 1ns/10ps
`default_nettype none

module ssw_top #(
   parameter int unsigned RST_LONG_CYCLES = ssw_pkg::RST_LONG_CYC,
   parameter int unsigned RST_STEP_CYCLES = ssw_pkg::RST_STEP_CYC,
   parameter int unsigned WD_LONG_CYCLES  = ssw_pkg::WD_LONG_CYC,
   parameter int unsigned WD_SHORT_CYCLES = ssw_pkg::WD_SHORT_CYC,
   parameter int unsigned WD_STEP_CYCLES  = ssw_pkg::WD_STEP_CYC,
   parameter int unsigned WD_LOWER_CYCLES = ssw_pkg::WD_LOWER_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        supply_valid,
   input  wire logic        lockout_ok,
   input  wire logic        manual_reset_request_n,
   input  wire logic        watchdog_kick_input,
   output logic             reset_out,
   output logic             reset_out_oe
);
   import ssw_pkg::*;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // reset timeout length in cycles for a config code and capacitor
   function automatic logic [31:0] rst_cycles(input logic [1:0] cfg, input logic [7:0] cap);
      logic [31:0] c;
      c = 32'h0;
      case (cfg)
         CFG_HIGH: c = RST_LONG_CYCLES;
         CFG_OPEN: c = RST_SHORT_CYC;
         default:  c = 32'(cap) * RST_STEP_CYCLES;
      endcase
      if (c == 32'h0) begin
         c = 32'h1;
      end
      return c;
   endfunction

   // watchdog upper bound in cycles
   function automatic logic [31:0] wd_upper(input logic [1:0] cfg, input logic [7:0] cap);
      logic [31:0] c;
      c = 32'h0;
      case (cfg)
         CFG_HIGH: c = WD_LONG_CYCLES;
         CFG_OPEN: c = WD_SHORT_CYCLES;
         default:  c = 32'(cap) * WD_STEP_CYCLES;
      endcase
      if (c == 32'h0) begin
         c = 32'h1;
      end
      return c;
   endfunction

   // watchdog lower bound in cycles, windowed mode only
   function automatic logic [31:0] wd_lower(input logic [1:0] cfg, input logic [7:0] cap);
      logic [31:0] c;
      c = 32'h0;
      if (cfg == CFG_HIGH) begin
         c = WD_LOWER_CYCLES;
      end else begin
         c = wd_upper(cfg, cap) / WD_EXT_DIV;
      end
      return c;
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic       kick_prev_reg;
   logic       sup_ok;
   logic       uvlo_ok;
   logic       mr_n;
   logic       kick;

   // two flops on every asynchronous pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg     <= 4'h0;
         sync2_reg     <= 4'h0;
         kick_prev_reg <= 1'b0;
      end else begin
         sync1_reg     <= {watchdog_kick_input, manual_reset_request_n, lockout_ok, supply_valid};
         sync2_reg     <= sync1_reg;
         kick_prev_reg <= sync2_reg[3];
      end
   end

   assign sup_ok  = sync2_reg[0];
   assign uvlo_ok = sync2_reg[1];
   assign mr_n    = sync2_reg[2];
   assign kick    = sync2_reg[3];

   // ----------------------------------------------------------------
   // register file and APB slave
   // ----------------------------------------------------------------
   logic [1:0]  rst_cfg_reg,  rst_cfg_next;
   logic [1:0]  wd_cfg_reg,   wd_cfg_next;
   logic        win_reg,      win_next;
   logic [7:0]  rt_cap_reg,   rt_cap_next;
   logic [7:0]  wt_cap_reg,   wt_cap_next;
   logic        late_reg,     late_next;
   logic        early_reg,    early_next;
   logic [31:0] prdata_reg,   prdata_next;
   logic        pready_reg,   pready_next;
   logic        pslverr_reg,  pslverr_next;
   logic        wd_late_evt;
   logic        wd_early_evt;
   logic        wd_enabled;
   logic        rst_low_reg;
   logic [31:0] wd_cnt_reg;
   logic        setup_ph;
   logic        wr_acc;
   logic        mapped;

   assign setup_ph = psel && !penable;
   assign wr_acc   = psel && penable && pwrite && pready_reg;
   assign mapped   = (paddr == ADDR_CTRL) || (paddr == ADDR_CAP) ||
                     (paddr == ADDR_STATUS) || (paddr == ADDR_WDCNT);

   // next values of registers and the answer for the access phase
   always_comb begin
      rst_cfg_next = rst_cfg_reg;
      wd_cfg_next  = wd_cfg_reg;
      win_next     = win_reg;
      rt_cap_next  = rt_cap_reg;
      wt_cap_next  = wt_cap_reg;
      late_next    = late_reg;
      early_next   = early_reg;
      prdata_next  = prdata_reg;
      pslverr_next = pslverr_reg;
      pready_next  = 1'b1;
      if (wr_acc && paddr == ADDR_CTRL) begin
         rst_cfg_next = pwdata[CTRL_RT_LSB +: 2];
         wd_cfg_next  = pwdata[CTRL_WT_LSB +: 2];
         win_next     = pwdata[CTRL_WIN_BIT];
      end
      if (wr_acc && paddr == ADDR_CAP) begin
         rt_cap_next = pwdata[CAP_RT_LSB +: 8];
         wt_cap_next = pwdata[CAP_WT_LSB +: 8];
      end
      // write one to clear; a new event wins over the clear
      if (wr_acc && paddr == ADDR_STATUS) begin
         if (pwdata[ST_LATE_BIT]) begin
            late_next = 1'b0;
         end
         if (pwdata[ST_EARLY_BIT]) begin
            early_next = 1'b0;
         end
      end
      if (wd_late_evt) begin
         late_next = 1'b1;
      end
      if (wd_early_evt) begin
         early_next = 1'b1;
      end
      // read data prepared in the setup cycle
      if (setup_ph) begin
         prdata_next  = 32'h0;
         pslverr_next = !mapped;
         if (!pwrite) begin
            case (paddr)
               ADDR_CTRL: begin
                  prdata_next[CTRL_RT_LSB +: 2] = rst_cfg_reg;
                  prdata_next[CTRL_WT_LSB +: 2] = wd_cfg_reg;
                  prdata_next[CTRL_WIN_BIT]     = win_reg;
               end
               ADDR_CAP: begin
                  prdata_next[CAP_RT_LSB +: 8] = rt_cap_reg;
                  prdata_next[CAP_WT_LSB +: 8] = wt_cap_reg;
               end
               ADDR_STATUS: begin
                  prdata_next[ST_RST_BIT]   = rst_low_reg;
                  prdata_next[ST_SUP_BIT]   = sup_ok;
                  prdata_next[ST_UVLO_BIT]  = uvlo_ok;
                  prdata_next[ST_MR_BIT]    = mr_n;
                  prdata_next[ST_LATE_BIT]  = late_reg;
                  prdata_next[ST_EARLY_BIT] = early_reg;
                  prdata_next[ST_WDEN_BIT]  = wd_enabled;
               end
               ADDR_WDCNT: prdata_next = wd_cnt_reg;
               default:    prdata_next = 32'h0;
            endcase
         end
      end
   end

   // register update
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cfg_reg <= RST_CFG_RESET;
         wd_cfg_reg  <= WD_CFG_RESET;
         win_reg     <= WIN_RESET;
         rt_cap_reg  <= CAP_RESET;
         wt_cap_reg  <= CAP_RESET;
         late_reg    <= 1'b0;
         early_reg   <= 1'b0;
         prdata_reg  <= 32'h0;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         rst_cfg_reg <= rst_cfg_next;
         wd_cfg_reg  <= wd_cfg_next;
         win_reg     <= win_next;
         rt_cap_reg  <= rt_cap_next;
         wt_cap_reg  <= wt_cap_next;
         late_reg    <= late_next;
         early_reg   <= early_next;
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------------------------------
   // reset timer and watchdog
   // ----------------------------------------------------------------
   ssw_state_t  state_reg,   state_next;
   logic [31:0] rst_cnt_reg, rst_cnt_next;
   logic [31:0] wd_cnt_next;
   logic        rst_low_next;
   logic        cause;
   logic        kick_edge;

   assign cause      = !uvlo_ok || !sup_ok || !mr_n;
   assign wd_enabled = !(wd_cfg_reg == CFG_LOW && wt_cap_reg == 8'h00 && !kick);
   // falling edges only when windowed, any edge otherwise
   assign kick_edge  = win_reg ? (kick_prev_reg && !kick)
                               : (kick_prev_reg != kick);

   // next state, reset timer and watchdog timer
   always_comb begin
      state_next   = state_reg;
      rst_cnt_next = rst_cnt_reg;
      wd_cnt_next  = wd_cnt_reg;
      rst_low_next = 1'b1;
      wd_late_evt  = 1'b0;
      wd_early_evt = 1'b0;
      case (state_reg)
         SSW_HOLD: begin
            rst_cnt_next = 32'h0;
            wd_cnt_next  = 32'h0;
            if (!cause) begin
               state_next = SSW_TIMEOUT;
            end
         end
         SSW_TIMEOUT: begin
            wd_cnt_next = 32'h0;
            if (cause) begin
               state_next   = SSW_HOLD;
               rst_cnt_next = 32'h0;
            end else if (rst_cnt_reg + 32'h1 >= rst_cycles(rst_cfg_reg, rt_cap_reg)) begin
               state_next   = SSW_RUN;
               rst_cnt_next = 32'h0;
               rst_low_next = 1'b0;
            end else begin
               rst_cnt_next = rst_cnt_reg + 32'h1;
            end
         end
         SSW_RUN: begin
            rst_low_next = 1'b0;
            if (cause) begin
               state_next   = SSW_HOLD;
               wd_cnt_next  = 32'h0;
               rst_low_next = 1'b1;
            end else if (!wd_enabled) begin
               wd_cnt_next = 32'h0;
            end else if (kick_edge && win_reg &&
                         wd_cnt_reg < wd_lower(wd_cfg_reg, wt_cap_reg)) begin
               wd_early_evt = 1'b1;
               state_next   = SSW_TIMEOUT;
               wd_cnt_next  = 32'h0;
               rst_low_next = 1'b1;
            end else if (kick_edge) begin
               wd_cnt_next = 32'h0;
            end else if (wd_cnt_reg + 32'h1 >= wd_upper(wd_cfg_reg, wt_cap_reg)) begin
               wd_late_evt  = 1'b1;
               state_next   = SSW_TIMEOUT;
               wd_cnt_next  = 32'h0;
               rst_low_next = 1'b1;
            end else begin
               wd_cnt_next = wd_cnt_reg + 32'h1;
            end
         end
         default: begin
            state_next   = SSW_HOLD;
            rst_cnt_next = 32'h0;
            wd_cnt_next  = 32'h0;
         end
      endcase
   end

   // state registers; reset output pulls low from reset onward
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= SSW_HOLD;
         rst_cnt_reg <= 32'h0;
         wd_cnt_reg  <= 32'h0;
         rst_low_reg <= 1'b1;
      end else begin
         state_reg   <= state_next;
         rst_cnt_reg <= rst_cnt_next;
         wd_cnt_reg  <= wd_cnt_next;
         rst_low_reg <= rst_low_next;
      end
   end

   // open-drain output: drives only low, enable high while pulling down
   logic reset_out_reg;

   // constant low drive level held in a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_out_reg <= 1'b0;
      end else begin
         reset_out_reg <= 1'b0;
      end
   end

   assign reset_out    = reset_out_reg;
   assign reset_out_oe = rst_low_reg;

endmodule

`default_nettype wire

// ### rtl/ssw_pkg.sv
// constants for the supply supervisor and watchdog timing core
// assumes a 10 MHz pclk and an APB master with 32-bit data
//
// Contract
// - reset output held low while monitored supply is invalid
// - after supply returns valid, reset stays low one full reset timeout
// - supply loss during the timeout clears it; full restart when valid again
// - reset held low while device supply is under lockout
// - manual reset low forces reset; release one timeout after it rises
// - external reset capacitor gives nine milliseconds per nanofarad
// - floating reset delay config gives about 400 microseconds
// - reset delay config tied high gives about 200 milliseconds
// - watchdog config high gives upper bound of 1.6 seconds nominal
// - windowed internal period uses a 50 millisecond lower bound
// - floating watchdog config gives about 3.2 milliseconds upper bound
// - external watchdog capacitor gives 72 milliseconds per nanofarad
// - windowed external period lower bound is upper bound over 32
// - windowed kick interval must sit between lower and upper bounds
// - windowed mode counts only falling kick edges
// - plain mode accepts any kick edge, no lower bound check
// - long internal watchdog timeout about 1.6 seconds when config high
package ssw_pkg;

   // ----------------------------------------------------------------
   // clock and times
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned T_RST_LONG_MS   = 200;
   localparam int unsigned T_RST_SHORT_US  = 400;
   localparam int unsigned T_RST_PER_NF_MS = 9;
   localparam int unsigned T_WD_LONG_MS    = 1600;
   localparam int unsigned T_WD_SHORT_US   = 3200;
   localparam int unsigned T_WD_PER_NF_MS  = 72;
   localparam int unsigned T_WD_LOWER_MS   = 50;
   localparam int unsigned WD_EXT_DIV      = 32;
   localparam int unsigned CAP_STEPS_NF    = 10;   // cap fields count tenths of nF

   localparam int unsigned RST_LONG_CYC    = T_RST_LONG_MS * (CLK_HZ / 1000);
   localparam int unsigned RST_SHORT_CYC   = T_RST_SHORT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned RST_STEP_CYC    = T_RST_PER_NF_MS * (CLK_HZ / 1000) / CAP_STEPS_NF;
   localparam int unsigned WD_LONG_CYC     = T_WD_LONG_MS * (CLK_HZ / 1000);
   localparam int unsigned WD_SHORT_CYC    = T_WD_SHORT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned WD_STEP_CYC     = T_WD_PER_NF_MS * (CLK_HZ / 1000) / CAP_STEPS_NF;
   localparam int unsigned WD_LOWER_CYC    = T_WD_LOWER_MS * (CLK_HZ / 1000);

   // ----------------------------------------------------------------
   // three-level configuration codes
   // ----------------------------------------------------------------
   localparam logic [1:0] CFG_LOW   = 2'h0;   // tied low or external capacitor
   localparam logic [1:0] CFG_OPEN  = 2'h1;   // left floating
   localparam logic [1:0] CFG_HIGH  = 2'h2;   // tied high

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CAP    = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_WDCNT  = 8'h0C;

   localparam int unsigned CTRL_RT_LSB  = 0;
   localparam int unsigned CTRL_WT_LSB  = 2;
   localparam int unsigned CTRL_WIN_BIT = 4;
   localparam int unsigned CAP_RT_LSB   = 0;
   localparam int unsigned CAP_WT_LSB   = 8;

   localparam int unsigned ST_RST_BIT   = 0;
   localparam int unsigned ST_SUP_BIT   = 1;
   localparam int unsigned ST_UVLO_BIT  = 2;
   localparam int unsigned ST_MR_BIT    = 3;
   localparam int unsigned ST_LATE_BIT  = 4;
   localparam int unsigned ST_EARLY_BIT = 5;
   localparam int unsigned ST_WDEN_BIT  = 6;

   localparam logic [1:0] RST_CFG_RESET = CFG_HIGH;
   localparam logic [1:0] WD_CFG_RESET  = CFG_HIGH;
   localparam logic       WIN_RESET     = 1'b0;
   localparam logic [7:0] CAP_RESET     = 8'h16;   // 2.2 nF

   // supervisor states
   typedef enum logic [1:0] {
      SSW_HOLD,      // a reset cause is present
      SSW_TIMEOUT,   // cause gone, reset timeout running
      SSW_RUN        // reset released, watchdog running
   } ssw_state_t;

endpackage

// ### test/ssw_checker_asserts.sv
// checker for the supervisor timing core, attached to ssw_top by bind
// assumes the timing configuration only changes through APB writes
`timescale 1ns/10ps
`default_nettype none

module ssw_checker
   import ssw_pkg::*;
#(
   parameter int unsigned RST_LONG_CYCLES = RST_LONG_CYC,
   parameter int unsigned RST_STEP_CYCLES = RST_STEP_CYC,
   parameter int unsigned WD_LONG_CYCLES  = WD_LONG_CYC,
   parameter int unsigned WD_SHORT_CYCLES = WD_SHORT_CYC,
   parameter int unsigned WD_STEP_CYCLES  = WD_STEP_CYC,
   parameter int unsigned WD_LOWER_CYCLES = WD_LOWER_CYC
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        supply_valid,
   input wire logic        lockout_ok,
   input wire logic        manual_reset_request_n,
   input wire logic        watchdog_kick_input,
   input wire logic        reset_out_oe
);
   // ------------------------------------------------------------
   // configuration shadow and helper counters
   // ------------------------------------------------------------
   logic [4:0]  ctrl_reg, ctrl_next;
   logic [15:0] cap_reg, cap_next;
   logic [31:0] wd_reg, wd_next, good_reg, good_next, hold_reg, hold_next;
   logic [31:0] rst_cyc, wd_cyc, lo_cyc;
   logic        kick_reg, ok, fall, wd_en, wr;

   // next values from bus writes and pins
   always_comb begin
      wr = psel && penable && pwrite && pready;
      ctrl_next = (wr && paddr == ADDR_CTRL) ? pwdata[4:0] : ctrl_reg;
      cap_next = (wr && paddr == ADDR_CAP) ? pwdata[15:0] : cap_reg;
      ok = supply_valid && lockout_ok && manual_reset_request_n;
      fall = kick_reg && !watchdog_kick_input;
      wd_en = ctrl_reg[3:2] != CFG_LOW || cap_reg[15:8] != 8'h00 || watchdog_kick_input;
      rst_cyc = ctrl_reg[1:0] == CFG_HIGH ? RST_LONG_CYCLES : ctrl_reg[1:0] == CFG_OPEN ?
                RST_SHORT_CYC : cap_reg[7:0] * RST_STEP_CYCLES;
      wd_cyc = ctrl_reg[3:2] == CFG_HIGH ? WD_LONG_CYCLES : ctrl_reg[3:2] == CFG_OPEN ?
               WD_SHORT_CYCLES : cap_reg[15:8] * WD_STEP_CYCLES;
      lo_cyc = ctrl_reg[3:2] == CFG_HIGH ? WD_LOWER_CYCLES : wd_cyc / WD_EXT_DIV;
      wd_next = (reset_out_oe || (ctrl_reg[4] ? fall : kick_reg != watchdog_kick_input)) ?
                '0 : wd_reg + 1;
      good_next = ok ? good_reg + 1 : '0;
      hold_next = (reset_out_oe && ok) ? hold_reg + 1 : '0;
   end

   // register the helpers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= {WIN_RESET, WD_CFG_RESET, RST_CFG_RESET};
         cap_reg  <= {CAP_RESET, CAP_RESET};
         wd_reg   <= '0;
         good_reg <= '0;
         hold_reg <= '0;
         kick_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         cap_reg  <= cap_next;
         wd_reg   <= wd_next;
         good_reg <= good_next;
         hold_reg <= hold_next;
         kick_reg <= watchdog_kick_input;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   supply_low_a: assert property (!supply_valid [*4] |=> reset_out_oe)
      else $error("reset released while supply low");
   lockout_low_a: assert property (!lockout_ok [*4] |=> reset_out_oe)
      else $error("reset released under lockout");
   manual_low_a: assert property (!manual_reset_request_n [*4] |=> reset_out_oe)
      else $error("reset released while manual request low");
   hold_len_a: assert property ($fell(reset_out_oe) |->
      hold_reg + 2 >= rst_cyc && hold_reg <= rst_cyc + 5)
      else $error("reset timeout length wrong");
   wd_late_a: assert property (!reset_out_oe && wd_en |-> wd_reg < wd_cyc + 4)
      else $error("missing kick did not assert reset");
   wd_early_a: assert property (ctrl_reg[4] && fall && !reset_out_oe && good_reg > 4
      && wd_reg + 3 < lo_cyc |-> ##[1:5] reset_out_oe)
      else $error("early kick did not assert reset");
   kick_ok_a: assert property (!reset_out_oe && good_reg > 4 && wd_reg + 4 < wd_cyc
      && (ctrl_reg[4] ? fall && wd_reg > lo_cyc + 3 : kick_reg != watchdog_kick_input)
      |=> (!reset_out_oe || good_reg < 4) [*4])
      else $error("valid kick caused reset");
   wd_off_a: assert property (!wd_en && !reset_out_oe && good_reg > 4 |=> !reset_out_oe)
      else $error("disabled watchdog asserted reset");

   cover property ($fell(reset_out_oe));
   cover property (ctrl_reg[4] && fall && wd_reg + 3 < lo_cyc);
   cover property (!wd_en && good_reg > 1000);
   cover property (!reset_out_oe ##1 reset_out_oe && good_reg > 8);
endmodule

bind ssw_top ssw_checker #(
   .RST_LONG_CYCLES(RST_LONG_CYCLES), .RST_STEP_CYCLES(RST_STEP_CYCLES),
   .WD_LONG_CYCLES(WD_LONG_CYCLES), .WD_SHORT_CYCLES(WD_SHORT_CYCLES),
   .WD_STEP_CYCLES(WD_STEP_CYCLES), .WD_LOWER_CYCLES(WD_LOWER_CYCLES)
) u_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .supply_valid,
   .lockout_ok, .manual_reset_request_n, .watchdog_kick_input, .reset_out_oe
);
`default_nettype wire

// ### test/ssw_host_model.sv
// host processor model: toggles the kick line while it is out of reset
// assumes rst_line is the resolved open-drain reset wire
`timescale 1ns/10ps
`default_nettype none

module ssw_host_model (
   input  wire logic        pclk,
   input  wire logic        rst_line,
   input  wire logic        kick_en,
   input  wire logic [15:0] half,
   output logic             kick
);
   logic [15:0] cnt;

   initial kick = 1'b0;

   // kick toggles every half cycles, held low in reset or when idle
   always @(posedge pclk) begin
      if (!rst_line || !kick_en) begin
         kick <= 1'b0;
         cnt  <= '0;
      end else if (cnt + 16'h0001 >= half) begin
         kick <= !kick;
         cnt  <= '0;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ### test/tb_supply_supervisor_watchdog_reset.sv
// self-checking bench for the supervisor timing core with a host model
// assumes shortened timing parameters; expectations kept in a queue
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, n) begin total_checks++; if (((a) >= n.lo && (a) <= n.hi) !== 1'b1) begin \
   n_mismatch++; $display("mismatch at %0t: got %h want %h..%h", $time, a, n.lo, n.hi); end end

module tb_supply_supervisor_watchdog_reset;
   import ssw_pkg::*;
   typedef struct {logic [32:0] lo; logic [32:0] hi;} ssw_note_t;
   localparam ssw_note_t LOW_NOTE = '{33'h0, 33'h0};   // open-drain data must stay low
   localparam int RL = 200, RS = 20, WL = 400, WS = 100, WP = 50, WO = 40;
   // ------------------------------------------------------------
   // stimulus, model and checking
   // ------------------------------------------------------------
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic        pready, pslverr, reset_out, reset_out_oe, kick, kick_en = 1'b1, oe_q = 1'b1;
   logic [2:0]  good = 3'h7;
   logic [15:0] half = 16'h0064;
   ssw_note_t   exp_q[$];
   int          n_mismatch = 0, total_checks = 0, cyc = 0, rst_n = RL, wd, rc;
   wire         rst_line = reset_out_oe ? reset_out : 1'b1;

   ssw_top #(.RST_LONG_CYCLES(RL), .RST_STEP_CYCLES(RS), .WD_LONG_CYCLES(WL),
      .WD_SHORT_CYCLES(WS), .WD_STEP_CYCLES(WP), .WD_LOWER_CYCLES(WO)) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .supply_valid(good[0]), .lockout_ok(good[1]), .manual_reset_request_n(good[2]),
      .watchdog_kick_input(kick), .reset_out, .reset_out_oe);
   ssw_host_model host (.pclk, .rst_line, .kick_en, .half, .kick);

   always #50 pclk = ~pclk;

   // cycle count and hang limit
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc > 40000) begin
         n_mismatch++;
         results();
      end
   end

   // watch read data and reset pin changes against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) take({pslverr, prdata});
      if (presetn && reset_out_oe !== oe_q) begin
         take({reset_out_oe, 32'(cyc)});
         `CHK(reset_out, LOW_NOTE)
      end
      oe_q <= reset_out_oe;
   end

   task automatic take(input logic [32:0] a);
      ssw_note_t n;
      if (exp_q.size() == 0) begin
         n_mismatch++;
         $display("mismatch at %0t: unexpected %h", $time, a);
      end else begin
         n = exp_q.pop_front();
         `CHK(a, n)
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] v);
      exp_q.push_back('{v, v});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic note(input logic v, input int lo, input int hi);
      exp_q.push_back('{{v, 32'(cyc + lo)}, {v, 32'(cyc + hi)}});
   endtask

   task automatic hold(input logic v);
      for (int i = 0; i < 6000 && reset_out_oe !== v; i++) @(posedge pclk);
   endtask

   // drive one reset cause and expect the pin to follow
   task automatic cause(input int i, input logic v);
      good[i] <= v;
      note(!v, v ? rst_n - 3 : 1, v ? rst_n + 6 : 6);
      hold(!v);
   endtask

   task automatic results();
      if (exp_q.size() != 0) n_mismatch++;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      void'($urandom(32'h81BD));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_CTRL, 33'h00000000A);
      rd(ADDR_CAP, 33'h000001616);
      rd(8'h10, 33'h100000000);
      note(1'b0, RL - 15, RL + 6);
      hold(1'b0);
      $display("power-up test done");
      for (int i = 0; i < 3; i++) begin
         cause(i, 1'b0);
         repeat (40) @(posedge pclk);
         good[i] <= 1'b1;
         repeat (60) @(posedge pclk);
         good[i] <= 1'b0;
         repeat (10) @(posedge pclk);
         cause(i, 1'b1);
      end
      $display("reset cause test done");
      for (int k = 0; k < 2; k++) begin
         rc = $urandom_range(40, 1);
         cause(2, 1'b0);
         apb(1'b1, ADDR_CTRL, k ? 32'h8 : 32'h9);
         apb(1'b1, ADDR_CAP, {16'h0, 8'h16, 8'(rc)});
         rst_n = k ? rc * RS : RST_SHORT_CYC;
         cause(2, 1'b1);
      end
      $display("reset delay test done");
      for (int k = 0; k < 3; k++) begin
         rc = $urandom_range(20, 2);
         wd = k == 0 ? WL : k == 1 ? WS : rc * WP;
         kick_en <= 1'b0;
         half <= 16'(wd / 4);
         cause(2, 1'b0);
         rst_n = RL;
         apb(1'b1, ADDR_CAP, {16'h0, 8'(rc), 8'h16});
         apb(1'b1, ADDR_CTRL, {28'h0, 2'(2 - k), 2'h2});
         cause(2, 1'b1);
         note(1'b1, wd - 3, wd + 6);
         hold(1'b1);
         note(1'b0, RL - 3, RL + 6);
         kick_en <= 1'b1;
         hold(1'b0);
         repeat (3 * wd) @(posedge pclk);
      end
      rd(ADDR_STATUS, 33'h05E);
      apb(1'b1, ADDR_STATUS, 32'h30);
      rd(ADDR_STATUS, 33'h04E);
      $display("watchdog timeout test done");
      for (int k = 0; k < 2; k++) begin
         cause(2, 1'b0);
         apb(1'b1, ADDR_STATUS, 32'h30);
         apb(1'b1, ADDR_CAP, 32'h1616);
         apb(1'b1, ADDR_CTRL, k ? 32'h12 : 32'h1A);
         half <= 16'h001E;
         cause(2, 1'b1);
         repeat (1000) @(posedge pclk);
         half <= 16'h000A;
         note(1'b1, 1, 80);
         hold(1'b1);
         half <= 16'h0064;
         note(1'b0, RL - 3, RL + 6);
         hold(1'b0);
         rd(ADDR_STATUS, 33'h06E);
      end
      $display("windowed test done");
      cause(2, 1'b0);
      kick_en <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h2);
      apb(1'b1, ADDR_CAP, 32'h16);
      cause(2, 1'b1);
      repeat (2000) @(posedge pclk);
      $display("disable test done");
      results();
   end
endmodule
`default_nettype wire
